// ### hdl/sfp_defs.svh
// Constants for the serial flash pause, write-protect and status block
// Function
// - Pause pin falling while serial clock low enters the paused state.
// - Pause pin falling while clock high enters pause at next clock low.
// - Pause pin rising while serial clock low leaves the paused state.
// - Pause pin rising while clock high leaves pause at next clock low.
// - While paused, output floats; input and clock ignored; sequence state kept.
// - Deselect while paused resets interface; host resumes by raising pause, reselecting.
// - Status write refused when protect pin low and lock bit set.
// - Bit 0 shows busy, read-only, zero at power-up.
// - Bit 1 shows write enable latch; zero latch refuses program and erase.
// - Latch clears at power-up and after disable, byte program, erase, status write; auto-increment keeps it.
// - Bit 6 shows auto-increment mode, read-only, single-byte at power-up.
// - Bits 2 to 4 pick protected region; writes inside it are blocked.
// - Full-array erase runs only when all four level bits are zero.
// - Level bits 2 to 4 one at power-up; bit 5 and lock zero.
// - Protect pin low with lock set freezes lock and level bits.
// - Level codes map to none, top 1/16, 1/8, 1/4, 1/2, whole array.
// - Bit 5 is reserved, does not change the region, defaults zero.
// - Status read repeats the status byte until chip select rises.
`ifndef SFP_DEFS_SVH
`define SFP_DEFS_SVH

`define SFP_OPC_READ_STATUS 8'h05
`define SFP_OPC_WRITE_STATUS 8'h01
`define SFP_OPC_WRITE_ENABLE 8'h06
`define SFP_OPC_WRITE_DISABLE 8'h04
`define SFP_OPC_BYTE_PROG 8'h02
`define SFP_OPC_AINC_PROG 8'hAD
`define SFP_OPC_SECTOR_ERASE 8'h20
`define SFP_OPC_BLOCK32_ERASE 8'h52
`define SFP_OPC_BLOCK64_ERASE 8'hD8
`define SFP_OPC_CHIP_ERASE_A 8'h60
`define SFP_OPC_CHIP_ERASE_B 8'hC7

`define SFP_BIT_BUSY 0
`define SFP_BIT_WLATCH 1
`define SFP_BIT_LVL_LO 2
`define SFP_BIT_LVL_HI 5
`define SFP_BIT_AINC 6
`define SFP_BIT_LOCK 7

`define SFP_LVL_RESET 4'h7
`define SFP_LVL_ZERO 4'h0

`define SFP_PROT_1_16 20'hF_0000
`define SFP_PROT_1_8 20'hE_0000
`define SFP_PROT_1_4 20'hC_0000
`define SFP_PROT_1_2 20'h8_0000
`define SFP_PROT_ALL 20'h0_0000

`define SFP_BYTES_ERASE 3'h3
`define SFP_BYTES_PROG 3'h4
`define SFP_BYTES_AINC_FIRST 3'h5
`define SFP_BYTES_AINC_NEXT 3'h2
`define SFP_BYTES_STATUS 3'h1
`define SFP_BYTES_NONE 3'h0
`define SFP_BYTES_MAX 3'h7
`define SFP_AINC_STEP 21'h0_0002
`define SFP_BIT_LAST 3'h7

`endif

// ### hdl/sfp_pkg.sv
// Types shared by the serial flash status block
package sfp_pkg;
    typedef enum logic [2:0] {
        SFP_OP_PROGRAM,
        SFP_OP_AINC,
        SFP_OP_SECTOR,
        SFP_OP_BLOCK32,
        SFP_OP_BLOCK64,
        SFP_OP_CHIP
    } sfp_op_t;

    typedef enum logic [1:0] {
        SFP_PH_CMD,
        SFP_PH_ARG,
        SFP_PH_STAT
    } sfp_phase_t;
endpackage

// ### hdl/sfp_sync.sv
// Two-stage synchroniser for the serial pins
`timescale 1ns/1ps
module sfp_sync #(
    parameter int WIDTH = 5
) (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    // ----------------------------------------
    // Stages
    // ----------------------------------------
    // Resets to all ones: idle level of the active-low pins
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            meta_r <= '1;
            sync_r <= '1;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;
endmodule

// ### hdl/sfp_prot_decode.sv
// Protected-region decoder for the level bits
`timescale 1ns/1ps
`include "sfp_defs.svh"
module sfp_prot_decode (
    input wire logic [2:0] i_level,
    input wire logic [19:0] i_addr,
    output logic o_protected
);
    logic [19:0] floor_addr;
    logic none;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    // The reserved fourth level bit is not an input at all
    always_comb begin
        none = 1'b0;
        floor_addr = `SFP_PROT_ALL;
        case (i_level)
            3'h0: none = 1'b1;
            3'h1: floor_addr = `SFP_PROT_1_16;
            3'h2: floor_addr = `SFP_PROT_1_8;
            3'h3: floor_addr = `SFP_PROT_1_4;
            3'h4: floor_addr = `SFP_PROT_1_2;
            default: floor_addr = `SFP_PROT_ALL;
        endcase
        o_protected = !none && (i_addr >= floor_addr);
    end
endmodule

// ### hdl/sfp_top.sv
// Serial flash pause control, write protection and status register
`timescale 1ns/1ps
`include "sfp_defs.svh"
module sfp_top
    import sfp_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_cs_n,
    input wire logic i_sck,
    input wire logic i_si,
    input wire logic i_hold_n,
    input wire logic i_wp_n,
    input wire logic i_op_done,
    output logic o_so,
    output logic o_so_oe,
    output logic o_op_start,
    output sfp_op_t o_op_kind,
    output logic [23:0] o_op_addr,
    output logic [15:0] o_op_data,
    output logic [7:0] o_status,
    output logic o_paused
);
    // ----------------------------------------
    // Pin sampling
    // ----------------------------------------
    logic [4:0] pins;
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic wp_n;

    sfp_sync #(.WIDTH(5)) u_sync (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_async({i_cs_n, i_sck, i_si, i_hold_n, i_wp_n}),
        .o_sync(pins)
    );
    assign {cs_n, sck, si, hold_n, wp_n} = pins;

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic sck_d_r, sck_d_nxt;
    logic cs_d_r, cs_d_nxt;
    logic paused_r, paused_nxt;
    sfp_phase_t phase_r, phase_nxt;
    logic [2:0] bitcnt_r, bitcnt_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [7:0] cmd_r, cmd_nxt;
    logic [2:0] nbytes_r, nbytes_nxt;
    logic [39:0] args_r, args_nxt;
    logic [2:0] out_idx_r, out_idx_nxt;
    logic [7:0] snap_r, snap_nxt;
    logic busy_r, busy_nxt;
    logic wlatch_r, wlatch_nxt;
    logic ainc_r, ainc_nxt;
    logic [3:0] lvl_r, lvl_nxt;
    logic lock_r, lock_nxt;
    logic [20:0] ainc_addr_r, ainc_addr_nxt;
    sfp_op_t kind_r, kind_nxt;
    logic so_r, so_nxt;
    logic so_oe_r, so_oe_nxt;
    logic start_r, start_nxt;
    logic [23:0] op_addr_r, op_addr_nxt;
    logic [15:0] op_data_r, op_data_nxt;

    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic [7:0] byte_in;
    logic [7:0] status;
    logic [19:0] chk_addr;
    logic chk_prot;
    logic locked;

    assign sck_rise = sck && !sck_d_r;
    assign sck_fall = !sck && sck_d_r;
    assign cs_rise = cs_n && !cs_d_r;
    assign byte_in = {shift_r[6:0], si};
    assign status = {lock_r, ainc_r, lvl_r, wlatch_r, busy_r};
    assign locked = !wp_n && lock_r;

    // Byte program carries one data byte after the address, auto-increment two; others end on it
    always_comb begin
        case (cmd_r)
            `SFP_OPC_BYTE_PROG: chk_addr = args_r[27:8];
            `SFP_OPC_AINC_PROG: chk_addr = ainc_r ? ainc_addr_r[19:0] : args_r[35:16];
            default: chk_addr = args_r[19:0];
        endcase
        if (busy_r) begin
            chk_addr = ainc_addr_r[19:0];
        end
    end

    sfp_prot_decode u_prot (
        .i_level(lvl_r[2:0]),
        .i_addr(chk_addr),
        .o_protected(chk_prot)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        sck_d_nxt = sck;
        cs_d_nxt = cs_n;
        paused_nxt = paused_r;
        phase_nxt = phase_r;
        bitcnt_nxt = bitcnt_r;
        shift_nxt = shift_r;
        cmd_nxt = cmd_r;
        nbytes_nxt = nbytes_r;
        args_nxt = args_r;
        out_idx_nxt = out_idx_r;
        snap_nxt = snap_r;
        busy_nxt = busy_r;
        wlatch_nxt = wlatch_r;
        ainc_nxt = ainc_r;
        lvl_nxt = lvl_r;
        lock_nxt = lock_r;
        ainc_addr_nxt = ainc_addr_r;
        kind_nxt = kind_r;
        so_nxt = so_r;
        start_nxt = 1'b0;
        op_addr_nxt = op_addr_r;
        op_data_nxt = op_data_r;

        // While selected, pause follows the pin only in the clock low phase, so a change seen
        // while the clock is high waits for the next low level by itself
        if (cs_n) begin
            paused_nxt = paused_r && !hold_n;
        end else if (!sck) begin
            paused_nxt = !hold_n;
        end

        if (cs_n) begin
            phase_nxt = SFP_PH_CMD;
            bitcnt_nxt = '0;
            shift_nxt = '0;
            out_idx_nxt = '0;
        end else if (!paused_r) begin
            // Clock edges while paused never reach the counters
            if (sck_rise && phase_r != SFP_PH_STAT) begin
                shift_nxt = byte_in;
                bitcnt_nxt = bitcnt_r + 3'h1;
                if (bitcnt_r == `SFP_BIT_LAST) begin
                    if (phase_r == SFP_PH_CMD) begin
                        cmd_nxt = byte_in;
                        nbytes_nxt = `SFP_BYTES_NONE;
                        if (byte_in == `SFP_OPC_READ_STATUS) begin
                            phase_nxt = SFP_PH_STAT;
                        end else begin
                            phase_nxt = SFP_PH_ARG;
                        end
                    end else begin
                        args_nxt = {args_r[31:0], byte_in};
                        if (nbytes_r != `SFP_BYTES_MAX) begin
                            nbytes_nxt = nbytes_r + 3'h1;
                        end
                    end
                end
            end
            if (sck_fall && phase_r == SFP_PH_STAT) begin
                // Fresh snapshot at each byte so polling sees busy drop
                if (out_idx_r == 3'h0) begin
                    snap_nxt = status;
                    so_nxt = status[`SFP_BIT_LOCK];
                end else begin
                    so_nxt = snap_r[~out_idx_r];
                end
                out_idx_nxt = out_idx_r + 3'h1;
            end
        end
        so_oe_nxt = !cs_n && !paused_nxt && phase_r == SFP_PH_STAT;

        // Command execution on deselect; while busy only status polling works
        if (cs_rise && !paused_r && phase_r == SFP_PH_ARG && !busy_r) begin
            case (cmd_r)
                `SFP_OPC_WRITE_ENABLE: begin
                    if (nbytes_r == `SFP_BYTES_NONE) begin
                        wlatch_nxt = 1'b1;
                    end
                end
                `SFP_OPC_WRITE_DISABLE: begin
                    if (nbytes_r == `SFP_BYTES_NONE) begin
                        wlatch_nxt = 1'b0;
                        ainc_nxt = 1'b0;
                    end
                end
                `SFP_OPC_WRITE_STATUS: begin
                    if (nbytes_r == `SFP_BYTES_STATUS && wlatch_r) begin
                        wlatch_nxt = 1'b0;
                        if (!locked) begin
                            lvl_nxt = args_r[`SFP_BIT_LVL_HI:`SFP_BIT_LVL_LO];
                            lock_nxt = args_r[`SFP_BIT_LOCK];
                        end
                    end
                end
                `SFP_OPC_BYTE_PROG: begin
                    if (nbytes_r == `SFP_BYTES_PROG && wlatch_r && !chk_prot) begin
                        start_nxt = 1'b1;
                        kind_nxt = SFP_OP_PROGRAM;
                        op_addr_nxt = args_r[31:8];
                        op_data_nxt = {8'h00, args_r[7:0]};
                    end
                end
                `SFP_OPC_AINC_PROG: begin
                    if (!ainc_r && nbytes_r == `SFP_BYTES_AINC_FIRST && wlatch_r
                        && !chk_prot) begin
                        start_nxt = 1'b1;
                        ainc_nxt = 1'b1;
                        kind_nxt = SFP_OP_AINC;
                        op_addr_nxt = {args_r[39:17], 1'b0};
                        op_data_nxt = args_r[15:0];
                        ainc_addr_nxt = {1'b0, args_r[35:17], 1'b0} + `SFP_AINC_STEP;
                    end else if (ainc_r && nbytes_r == `SFP_BYTES_AINC_NEXT && wlatch_r) begin
                        start_nxt = 1'b1;
                        kind_nxt = SFP_OP_AINC;
                        op_addr_nxt = {4'h0, ainc_addr_r[19:0]};
                        op_data_nxt = args_r[15:0];
                        ainc_addr_nxt = ainc_addr_r + `SFP_AINC_STEP;
                    end
                end
                `SFP_OPC_SECTOR_ERASE, `SFP_OPC_BLOCK32_ERASE, `SFP_OPC_BLOCK64_ERASE: begin
                    if (nbytes_r == `SFP_BYTES_ERASE && wlatch_r && !chk_prot) begin
                        start_nxt = 1'b1;
                        op_addr_nxt = args_r[23:0];
                        op_data_nxt = '0;
                        if (cmd_r == `SFP_OPC_SECTOR_ERASE) begin
                            kind_nxt = SFP_OP_SECTOR;
                        end else if (cmd_r == `SFP_OPC_BLOCK32_ERASE) begin
                            kind_nxt = SFP_OP_BLOCK32;
                        end else begin
                            kind_nxt = SFP_OP_BLOCK64;
                        end
                    end
                end
                `SFP_OPC_CHIP_ERASE_A, `SFP_OPC_CHIP_ERASE_B: begin
                    if (nbytes_r == `SFP_BYTES_NONE && wlatch_r
                        && lvl_r == `SFP_LVL_ZERO) begin
                        start_nxt = 1'b1;
                        kind_nxt = SFP_OP_CHIP;
                        op_addr_nxt = '0;
                        op_data_nxt = '0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (start_nxt) begin
            busy_nxt = 1'b1;
        end

        // Completion from the array engine; auto-increment keeps the latch
        // until it runs into protected space or off the top of the array
        if (i_op_done && busy_r) begin
            busy_nxt = 1'b0;
            if (kind_r != SFP_OP_AINC || ainc_addr_r[20] || chk_prot) begin
                wlatch_nxt = 1'b0;
                ainc_nxt = 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            sck_d_r <= 1'b0;
            cs_d_r <= 1'b1;
            paused_r <= 1'b0;
            phase_r <= SFP_PH_CMD;
            bitcnt_r <= '0;
            shift_r <= '0;
            cmd_r <= '0;
            nbytes_r <= '0;
            args_r <= '0;
            out_idx_r <= '0;
            snap_r <= '0;
            busy_r <= 1'b0;
            wlatch_r <= 1'b0;
            ainc_r <= 1'b0;
            lvl_r <= `SFP_LVL_RESET;
            lock_r <= 1'b0;
            ainc_addr_r <= '0;
            kind_r <= SFP_OP_PROGRAM;
            so_r <= 1'b0;
            so_oe_r <= 1'b0;
            start_r <= 1'b0;
            op_addr_r <= '0;
            op_data_r <= '0;
        end else begin
            sck_d_r <= sck_d_nxt;
            cs_d_r <= cs_d_nxt;
            paused_r <= paused_nxt;
            phase_r <= phase_nxt;
            bitcnt_r <= bitcnt_nxt;
            shift_r <= shift_nxt;
            cmd_r <= cmd_nxt;
            nbytes_r <= nbytes_nxt;
            args_r <= args_nxt;
            out_idx_r <= out_idx_nxt;
            snap_r <= snap_nxt;
            busy_r <= busy_nxt;
            wlatch_r <= wlatch_nxt;
            ainc_r <= ainc_nxt;
            lvl_r <= lvl_nxt;
            lock_r <= lock_nxt;
            ainc_addr_r <= ainc_addr_nxt;
            kind_r <= kind_nxt;
            so_r <= so_nxt;
            so_oe_r <= so_oe_nxt;
            start_r <= start_nxt;
            op_addr_r <= op_addr_nxt;
            op_data_r <= op_data_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign o_so = so_r;
    assign o_so_oe = so_oe_r;
    assign o_op_start = start_r;
    assign o_op_kind = kind_r;
    assign o_op_addr = op_addr_r;
    assign o_op_data = op_data_r;
    assign o_status = {lock_r, ainc_r, lvl_r, wlatch_r, busy_r};
    assign o_paused = paused_r;
endmodule

// ### dv/sfp_props.sv
// Checker for the pause, protection and status outputs of the serial flash block
`timescale 1ns/1ps
module sfp_props
    import sfp_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_cs_n,
    input wire logic i_sck,
    input wire logic i_hold_n,
    input wire logic i_wp_n,
    input wire logic i_op_done,
    input wire logic o_so_oe,
    input wire logic o_op_start,
    input wire sfp_op_t o_op_kind,
    input wire logic [7:0] o_status,
    input wire logic o_paused
);
    logic [3:0] wp_cnt_r;
    logic [3:0] wp_cnt_nxt;

    // Steady-low time of the protect pin, so the synchroniser delay has surely passed
    always_comb begin
        wp_cnt_nxt = wp_cnt_r;
        if (i_wp_n) begin
            wp_cnt_nxt = 4'h0;
        end else if (wp_cnt_r != 4'hF) begin
            wp_cnt_nxt = wp_cnt_r + 4'h1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            wp_cnt_r <= 4'h0;
        end else begin
            wp_cnt_r <= wp_cnt_nxt;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    a_reset_value: assert property ($fell(i_srst) |-> o_status == 8'h1C && !o_paused
        && !o_so_oe && !o_op_start) else $error("status or outputs wrong after reset");
    a_hidden_paused: assert property (o_paused |-> !o_so_oe)
        else $error("serial output driven while paused");
    a_start_wel: assert property (o_op_start |-> $past(o_status[1]) && !$past(o_status[0]))
        else $error("operation started without latch or while busy");
    a_start_busy: assert property (o_op_start |=> o_status[0])
        else $error("busy not shown after operation start");
    a_done_clear: assert property ((i_op_done && o_status[0] && !o_status[6])
        |-> ##[1:2] (!o_status[0] && !o_status[1])) else $error("done did not clear busy and latch");
    a_chip_gate: assert property ((o_op_start && o_op_kind == SFP_OP_CHIP)
        |-> $past(o_status[5:2]) == 4'h0) else $error("full erase with level bits set");
    a_lock_freeze: assert property ((wp_cnt_r >= 4'h8 && o_status[7])
        |=> $stable(o_status[7:2])) else $error("locked level bits changed");
    a_pause_entry: assert property ($rose(o_paused)
        |-> (!$past(i_hold_n, 2) || !$past(i_hold_n, 3) || !$past(i_hold_n, 4))
        && (!$past(i_sck, 2) || !$past(i_sck, 3) || !$past(i_sck, 4)))
        else $error("pause entered without pause pin low in clock low phase");
    a_pause_exit: assert property (($fell(o_paused) && !$past(i_srst))
        |-> ($past(i_hold_n, 2) || $past(i_hold_n, 3) || $past(i_hold_n, 4))
        && (!$past(i_sck, 2) || !$past(i_sck, 3) || !$past(i_sck, 4)))
        else $error("pause left without pause pin high in clock low phase");
    a_oe_release: assert property ($rose(i_cs_n) |-> ##[1:6] !o_so_oe)
        else $error("serial output still driven after deselect");
endmodule

bind sfp_top sfp_props u_props (
    .i_clock,
    .i_srst,
    .i_cs_n,
    .i_sck,
    .i_hold_n,
    .i_wp_n,
    .i_op_done,
    .o_so_oe,
    .o_op_start,
    .o_op_kind,
    .o_status,
    .o_paused
);

// ### dv/sfp_host.sv
// SPI host model driving select, serial clock, data and pause pins in mode 0
`timescale 1ns/1ps
module sfp_host (
    input wire logic i_clock,
    input wire logic i_so,
    input wire logic i_paused,
    output logic o_cs_n,
    output logic o_sck,
    output logic o_si,
    output logic o_hold_n
);
    logic [7:0] rd;
    logic [3:0] pz;

    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b0;
        o_hold_n = 1'b1;
        rd = 8'h00;
        pz = 4'h0;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge i_clock);
    endtask

    // Four clocks per phase, so the sampled clock never loses an edge
    task automatic bit_slot(input logic b);
        o_sck <= 1'b0;
        o_si <= b;
        wt(4);
        o_sck <= 1'b1;
        wt(4);
        rd = {rd[6:0], i_so};
    endtask

    // Pause pin falls and rises in the high phase; a stray rise is sent while paused
    task automatic pause_mid();
        o_hold_n <= 1'b0;
        wt(8);
        pz[3] = i_paused;
        o_sck <= 1'b0;
        wt(8);
        pz[2] = i_paused;
        o_sck <= 1'b1;
        o_si <= ~o_si;
        wt(4);
        o_hold_n <= 1'b1;
        wt(8);
        pz[1] = i_paused;
        o_sck <= 1'b0;
        wt(8);
        pz[0] = i_paused;
    endtask

    task automatic sel();
        o_cs_n <= 1'b0;
        wt(6);
    endtask

    task automatic send(input logic [7:0] b, input int p);
        for (int i = 7; i >= 0; i--) begin
            bit_slot(b[i]);
            if (i == p) begin
                pause_mid();
            end
        end
    endtask

    // Data line toggles once deselected, so nothing can rely on a held level
    task automatic desel();
        o_sck <= 1'b0;
        wt(4);
        o_cs_n <= 1'b1;
        o_si <= ~o_si;
        wt(12);
    endtask

    // Half a byte, pause, deselect while paused, then release the pause pin
    task automatic abort_paused();
        sel();
        for (int i = 0; i < 4; i++) begin
            bit_slot(1'b1);
        end
        o_sck <= 1'b0;
        o_hold_n <= 1'b0;
        wt(8);
        o_cs_n <= 1'b1;
        wt(8);
        pz[0] = i_paused;
        o_hold_n <= 1'b1;
        wt(8);
    endtask
endmodule

// ### dv/testbench.sv
// Self-checking bench for the serial flash pause, protection and status block
`timescale 1ns/1ps
module testbench;
    import sfp_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic wp_n = 1'b1;
    logic done = 1'b0;
    logic cs_n, sck, si, hold_n, so, so_oe, start, paused;
    sfp_op_t kind;
    logic [23:0] addr;
    logic [15:0] data;
    logic [7:0] status;
    logic [7:0] exp;
    logic [3:0] lv;
    int error_cnt = 0;
    int num_checks = 0;
    int nstart = 0;
    logic [20:0] bnd [8] = '{21'h10_0000, 21'h0F_0000, 21'h0E_0000, 21'h0C_0000,
                             21'h08_0000, 21'h00_0000, 21'h00_0000, 21'h00_0000};
    logic [7:0] ops [4] = '{8'h02, 8'h20, 8'h52, 8'hD8};
    int nb [4] = '{4, 3, 3, 3};
    sfp_op_t kinds [4] = '{SFP_OP_PROGRAM, SFP_OP_SECTOR, SFP_OP_BLOCK32, SFP_OP_BLOCK64};
    logic [7:0] ainc_seq [6] = '{8'hAD, 8'h01, 8'h01, 8'h01, 8'h12, 8'h34};

    always #50 clk = ~clk;

    sfp_top DUT (.i_clock(clk), .i_srst(srst), .i_cs_n(cs_n), .i_sck(sck), .i_si(si),
        .i_hold_n(hold_n), .i_wp_n(wp_n), .i_op_done(done), .o_so(so), .o_so_oe(so_oe),
        .o_op_start(start), .o_op_kind(kind), .o_op_addr(addr), .o_op_data(data),
        .o_status(status), .o_paused(paused));
    sfp_host host (.i_clock(clk), .i_so(so), .i_paused(paused), .o_cs_n(cs_n), .o_sck(sck),
        .o_si(si), .o_hold_n(hold_n));

    always @(posedge clk) begin
        if (start) begin
            nstart <= nstart + 1;
        end
    end

    task automatic chk(input logic [23:0] seen, input logic [23:0] want);
        num_checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic cmd(input logic [7:0] op, input int n, input logic [23:0] a = 24'h00_0000,
                       input logic [7:0] d = 8'hA5);
        host.sel();
        host.send(op, -1);
        if (n >= 3) for (int i = 2; i >= 0; i--) host.send(a[8*i+:8], -1);
        if (n == 1 || n == 4) host.send(d, -1);
        host.desel();
    endtask

    // Two status bytes in one select: the byte repeats while the clock runs
    task automatic rd_status();
        host.sel();
        host.send(8'h05, -1);
        host.send(8'h00, -1);
        chk(24'(host.rd), 24'(exp));
        host.send(8'h00, -1);
        chk(24'(host.rd), 24'(exp));
        host.desel();
        chk(24'(status), 24'(exp));
    endtask

    task automatic try_op(input logic [7:0] op, input int n, input logic [23:0] a,
                          input logic ok, input sfp_op_t k);
        int n0;
        n0 = nstart;
        cmd(8'h06, 0);
        cmd(op, n, a);
        chk(24'(nstart - n0), 24'(ok));
        if (ok) begin
            chk(24'(kind), 24'(k));
            if (n != 0) chk(addr, a);
            chk(24'(data), (op == 8'h02) ? 24'h00_00A5 : 24'h00_0000);
            exp = exp | 8'h03;
            rd_status();
            done <= 1'b1;
            @(posedge clk);
            done <= 1'b0;
            exp = exp & 8'hFC;
        end else begin
            cmd(8'h04, 0);
            exp = exp & 8'hFD;
        end
        rd_status();
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        exp = 8'h1C;
        rd_status();
        cmd(8'h01, 1, 24'h00_0000, 8'h00);
        rd_status();
        cmd(8'h06, 0);
        exp = 8'h1E;
        rd_status();
        try_op(8'h02, 4, 24'h00_0100, 1'b0, SFP_OP_PROGRAM);
        cmd(8'h06, 0);
        cmd(8'h01, 1, 24'h00_0000, 8'hC7);
        exp = 8'h84;
        rd_status();
        wp_n <= 1'b0;
        cmd(8'h06, 0);
        cmd(8'h01, 1, 24'h00_0000, 8'h00);
        rd_status();
        wp_n <= 1'b1;
        cmd(8'h06, 0);
        cmd(8'h01, 1, 24'h00_0000, 8'h00);
        exp = 8'h00;
        rd_status();
        // Every level code; the last pass sets only the reserved level bit
        for (int i = 0; i < 9; i++) begin
            lv = {i == 8, i[2:0]};
            cmd(8'h06, 0);
            cmd(8'h01, 1, 24'h00_0000, {2'b00, lv, 2'b00});
            exp = {2'b00, lv, 2'b00};
            rd_status();
            if (bnd[i[2:0]] != 21'h00_0000)
                try_op(ops[i % 4], nb[i % 4], 24'(bnd[i[2:0]] - 21'h1), 1'b1, kinds[i % 4]);
            if (bnd[i[2:0]] != 21'h10_0000)
                try_op(ops[i % 4], nb[i % 4], 24'(bnd[i[2:0]]), 1'b0, kinds[i % 4]);
            try_op((i % 2 == 0) ? 8'hC7 : 8'h60, 0, 24'h00_0000, lv == 4'h0, SFP_OP_CHIP);
        end
        // Auto-increment start: mode and latch outlive a completed word
        cmd(8'h06, 0);
        host.sel();
        for (int j = 0; j < 6; j++) host.send(ainc_seq[j], -1);
        host.desel();
        chk(addr, 24'h01_0100);
        chk(24'(data), 24'h00_1234);
        exp = exp | 8'h43;
        rd_status();
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        exp = exp & 8'hFE;
        rd_status();
        cmd(8'h04, 0);
        exp = exp & 8'hBD;
        rd_status();
        host.sel();
        host.send(8'h06, 4);
        host.desel();
        chk(24'(host.pz), 24'h00_0006);
        exp = exp | 8'h02;
        rd_status();
        host.abort_paused();
        chk(24'(host.pz[0]), 24'h00_0001);
        cmd(8'h04, 0);
        exp = exp & 8'hFD;
        rd_status();
        print_verdict();
    end

    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end
endmodule
